// ---- fcrp_coef_mem.sv ----
`timescale 1ns/1ps
// coefficient word store, one write port, registered read port
module fcrp_coef_mem (
  input  wire logic                           mclk,  // system clock
  input  wire logic                           we,    // write strobe
  input  wire logic [fcrp_pkg::COEF_AW-1:0]   waddr, // write word address
  input  wire logic [31:0]                    wdata, // write word
  input  wire logic [fcrp_pkg::COEF_AW-1:0]   raddr, // read word address
  output logic      [31:0]                    rdata  // read word, one cycle late
);

  logic [31:0] mem [2**fcrp_pkg::COEF_AW]; // storage array, no reset

  // write port
  always_ff @(posedge mclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // read port, registered so it maps onto block ram
  always_ff @(posedge mclk)
  begin
    rdata <= mem[raddr];
  end

endmodule

// ---- fcrp_host.sv ----
`timescale 1ns/1ps
// host processor model: asynchronous strobes, one access at a time
module fcrp_host (
  input  wire logic       mclk,    // bench clock, only spaces the strobes
  input  wire logic [7:0] bus,     // resolved bus level
  output logic            store_n, // write strobe, active low
  output logic            read_n,  // read strobe, active low
  output logic      [2:0] sel,     // register select
  output logic      [7:0] drive    // host level, inverted once released
);
  // idle strobes from time zero
  initial
  begin
    store_n = 1'b1;
    read_n = 1'b1;
    sel = 3'h0;
    drive = 8'h00;
  end
  // select and data held 4 cycles past the rise; never both strobes low
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    sel = a;
    drive = v;
    store_n = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    store_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    drive = ~drive; // released: no stale value left on the wire
  endtask
  // select held until well after the strobe rises
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    sel = a;
    read_n = 1'b0;
    repeat (5) @(posedge mclk);
    v = bus;
    #1;
    read_n = 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule

// ---- fcrp_pkg.sv ----
package fcrp_pkg;

  // register select codes
  localparam logic [2:0] ADDR_FILTER_CFG = 3'h0;
  localparam logic [2:0] ADDR_TAP_COUNT  = 3'h1;
  localparam logic [2:0] ADDR_COEF_PORT  = 3'h2;
  localparam logic [2:0] ADDR_IN_FORMAT  = 3'h3;
  localparam logic [2:0] ADDR_OUT_TIMING = 3'h4;
  localparam logic [2:0] ADDR_OUT_FORMAT = 3'h5;
  localparam logic [2:0] ADDR_SYMMETRY   = 3'h6;
  localparam logic [2:0] ADDR_MIX_FORMAT = 3'h7;

  // writable bits per register; the rest read back as zero
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] MASK_IN_FORMAT  = 8'h7f;
  localparam logic [7:0] MASK_OUT_TIMING = 8'h3f;
  localparam logic [7:0] MASK_SYMMETRY   = 8'h03;
  localparam logic [7:0] MASK_MIX_FORMAT = 8'h7f;

  // reset values
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [12:0] SYNC_RESET = 13'h1800; // both strobes idle high

  // field positions
  localparam int HB_LSB         = 0;
  localparam int FIR_EN_BIT     = 3;
  localparam int COEF_RD_BIT    = 4;
  localparam int DEC_LSB        = 5;
  localparam int LEN_LSB        = 0;
  localparam int IN_OFFSET_BIT  = 5;
  localparam int IN_MSB_BIT     = 6;
  localparam int OUT_MSB_BIT    = 5;
  localparam int ROUND_BIT      = 5;
  localparam int OUT_OFFSET_BIT = 6;
  localparam int GAIN_BIT       = 7;
  localparam int SYM_LSB        = 0;
  localparam int MIX_MSB_BIT    = 5;
  localparam int MIX_SERIAL_BIT = 6;

  // field limits and encodings
  localparam logic [2:0] HB_MAX      = 3'h5;
  localparam logic [7:0] TAP_MIN     = 8'h04;
  localparam logic [4:0] WORD_MIN    = 5'h08;
  localparam logic [4:0] WORD_MAX    = 5'h18;
  localparam logic [1:0] SYM_EVEN    = 2'h0;
  localparam logic [1:0] SYM_NONE    = 2'h1;
  localparam logic [1:0] SYM_ODD     = 2'h2;

  // coefficient storage
  localparam int         COEF_AW    = 7;
  localparam logic [7:0] COEF_END   = 8'h80; // pointer halts here
  localparam logic [1:0] LAST_BYTE  = 2'h3;

  // 5-bit count where zero stands for 32
  function automatic logic [5:0] zero_is_32(input logic [4:0] v);
    zero_is_32 = (v == 5'h00) ? 6'h20 : {1'b0, v};
  endfunction

  // word length inside 8..24
  function automatic logic len_ok(input logic [4:0] v);
    len_ok = (v >= WORD_MIN) && (v <= WORD_MAX);
  endfunction

endpackage

// ---- fcrp_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs; stage one feeds stage two only
module fcrp_sync #(
  parameter int          WIDTH    = 1,
  parameter logic [12:0] RESET_V  = 13'h0000
) (
  input  wire logic             mclk,     // system clock
  input  wire logic             rst_n,    // sync reset, active low
  input  wire logic [WIDTH-1:0] async_in, // raw pins
  output logic      [WIDTH-1:0] sync_out  // resynchronised copy
);

  logic [WIDTH-1:0] meta; // first stage, may go metastable

  // both stages reset to the idle level of the pins
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      meta     <= RESET_V[WIDTH-1:0];
      sync_out <= RESET_V[WIDTH-1:0];
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- fcrp_top.sv ----
`timescale 1ns/1ps
// Function
// - eight 8-bit registers, 3-bit select, shared bus
// - store strobe falling edge writes addressed register
// - read strobe drives bus until it rises
// - register 0 bits 2-0: halfband count
// - register 0 bit 3: fir enable
// - bit 4 set: coefficient reads, writes blocked
// - register 0 bits 7-5: decimation, 000 is 8
// - register 1: tap count, zero is 256
// - writes to select 2 feed coefficient storage
// - register 3: input length, number system, order
// - register 4: bit clock divide, output order
// - register 5 bits 4-0: output length, zero 32
// - register 5: round select, output number system
// - register 5 bit 7: gain of two
// - register 6 bits 1-0: coefficient symmetry code
// - register 7: mix length and mix order
// - register 7 bit 6: mix factor source
// - four bytes, low first, then commit word
// - other register access resets coefficient pointer
module fcrp_top (
  input  wire logic       mclk,                // 100 MHz system clock
  input  wire logic       rst_n,               // sync reset, active low
  input  wire logic       store_strobe_n,      // write strobe pin, async
  input  wire logic       read_strobe_n,       // read strobe pin, async
  input  wire logic [2:0] reg_select,          // register select pins
  input  wire logic [7:0] config_bus_in,       // bus pins as seen
  output logic      [7:0] config_bus_out,      // bus value when driving
  output logic            config_bus_oe,       // high while driving bus
  output logic      [2:0] halfband_stage,      // cascaded halfband count
  output logic            halfband_invalid,    // count 6 or 7
  output logic            fir_enable,          // fir in path
  output logic            coef_read_enable,    // coefficient readback mode
  output logic      [3:0] fir_decimation,      // 1..8
  output logic      [8:0] fir_taps,            // 1..256
  output logic            fir_taps_invalid,    // 1..3 on symmetric set
  output logic      [4:0] input_word_length,   // input bits
  output logic            input_length_invalid,// outside 8..24
  output logic            input_offset_binary, // input number system
  output logic            input_msb_first,     // input bit order
  output logic      [5:0] output_bit_clock_div,// filter clocks per bit
  output logic            output_msb_first,    // output bit order
  output logic      [5:0] output_word_length,  // 1..32
  output logic            output_length_invalid,// 1..7
  output logic            output_round,        // round, else truncate
  output logic            output_offset_binary,// output number system
  output logic            output_gain_double,  // scale output by two
  output logic      [1:0] coef_symmetry,       // symmetry code
  output logic            symmetry_invalid,    // code 11
  output logic      [4:0] mix_word_length,     // mix factor bits
  output logic            mix_length_invalid,  // outside 8..24
  output logic            mix_msb_first,       // mix bit order
  output logic            mix_serial_select    // serial mix, else table
);

  // stored registers; select 2 has no storage of its own
  logic [7:0]  filter_configuration; // select 0
  logic [7:0]  fir_tap_count;        // select 1
  logic [7:0]  input_format;         // select 3
  logic [7:0]  output_timing;        // select 4
  logic [7:0]  output_format;        // select 5
  logic [7:0]  coefficient_symmetry; // select 6
  logic [7:0]  mix_factor_format;    // select 7

  logic [12:0] pin_raw;   // pins bundled for the synchroniser
  logic [12:0] pin_sync;  // resynchronised pins
  logic        store_s;   // synced store strobe
  logic        read_s;    // synced read strobe
  logic [2:0]  sel_s;     // synced select
  logic [7:0]  bus_s;     // synced bus
  logic        store_d;   // store strobe one cycle ago
  logic        read_d;    // read strobe one cycle ago
  logic        wr_fall;   // store strobe falling edge
  logic        rd_fall;   // read strobe falling edge

  logic [7:0]  coef_ptr;  // coefficient word pointer
  logic [1:0]  byte_idx;  // byte inside current word
  logic [23:0] coef_hold; // low three bytes waiting
  logic        mem_we;    // commit strobe into storage
  logic [31:0] mem_wdata; // committed word
  logic [6:0]  mem_waddr; // committed word address
  logic [31:0] mem_rdata; // word under the pointer
  logic        ptr_end;   // pointer parked past last word
  logic [7:0]  reg_view;  // value a read would return
  logic        coef_wr;   // accepted coefficient byte write
  logic        coef_rd;   // accepted coefficient byte read

  // all pins are async to mclk, so everything goes through two flops
  assign pin_raw = {store_strobe_n, read_strobe_n, reg_select, config_bus_in};

  fcrp_sync #(
    .WIDTH   (13),
    .RESET_V (fcrp_pkg::SYNC_RESET)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  assign store_s = pin_sync[12];
  assign read_s  = pin_sync[11];
  assign sel_s   = pin_sync[10:8];
  assign bus_s   = pin_sync[7:0];

  // strobe history for edge detection, idle high after reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      store_d <= 1'b1;
      read_d  <= 1'b1;
    end
    else
    begin
      store_d <= store_s;
      read_d  <= read_s;
    end
  end

  // edges are seen on synced copies, so select and data must still be
  // held a few mclk after the strobe edge on the pins
  assign wr_fall = store_d & ~store_s;
  assign rd_fall = read_d & ~read_s;

  assign ptr_end = (coef_ptr == fcrp_pkg::COEF_END);
  assign coef_wr = wr_fall && (sel_s == fcrp_pkg::ADDR_COEF_PORT)
                   && !filter_configuration[fcrp_pkg::COEF_RD_BIT] && !ptr_end;
  assign coef_rd = rd_fall && (sel_s == fcrp_pkg::ADDR_COEF_PORT)
                   && filter_configuration[fcrp_pkg::COEF_RD_BIT] && !ptr_end;

  // register writes on the store edge, unused bits masked off
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      filter_configuration <= fcrp_pkg::CFG_RESET;
      fir_tap_count        <= fcrp_pkg::CFG_RESET;
      input_format         <= fcrp_pkg::CFG_RESET;
      output_timing        <= fcrp_pkg::CFG_RESET;
      output_format        <= fcrp_pkg::CFG_RESET;
      coefficient_symmetry <= fcrp_pkg::CFG_RESET;
      mix_factor_format    <= fcrp_pkg::CFG_RESET;
    end
    else if (wr_fall)
    begin
      case (sel_s)
        fcrp_pkg::ADDR_FILTER_CFG: filter_configuration <= bus_s & fcrp_pkg::MASK_FULL;
        fcrp_pkg::ADDR_TAP_COUNT:  fir_tap_count        <= bus_s & fcrp_pkg::MASK_FULL;
        fcrp_pkg::ADDR_IN_FORMAT:  input_format         <= bus_s & fcrp_pkg::MASK_IN_FORMAT;
        fcrp_pkg::ADDR_OUT_TIMING: output_timing        <= bus_s & fcrp_pkg::MASK_OUT_TIMING;
        fcrp_pkg::ADDR_OUT_FORMAT: output_format        <= bus_s & fcrp_pkg::MASK_FULL;
        fcrp_pkg::ADDR_SYMMETRY:   coefficient_symmetry <= bus_s & fcrp_pkg::MASK_SYMMETRY;
        fcrp_pkg::ADDR_MIX_FORMAT: mix_factor_format    <= bus_s & fcrp_pkg::MASK_MIX_FORMAT;
        default:                   ; // select 2 goes to coefficient storage
      endcase
    end
  end

  // coefficient pointer, byte assembly and commit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      coef_ptr  <= 8'h00;
      byte_idx  <= 2'h0;
      coef_hold <= 24'h000000;
      mem_we    <= 1'b0;
      mem_wdata <= 32'h00000000;
      mem_waddr <= 7'h00;
    end
    else
    begin
      mem_we <= 1'b0;
      if ((wr_fall || rd_fall) && (sel_s != fcrp_pkg::ADDR_COEF_PORT))
      begin
        // any other register access restarts the sequence
        coef_ptr  <= 8'h00;
        byte_idx  <= 2'h0;
        coef_hold <= 24'h000000;
      end
      else if (coef_wr)
      begin
        if (byte_idx == fcrp_pkg::LAST_BYTE)
        begin
          // fourth byte completes the word
          mem_we    <= 1'b1;
          mem_wdata <= {bus_s, coef_hold};
          mem_waddr <= coef_ptr[fcrp_pkg::COEF_AW-1:0];
          coef_ptr  <= coef_ptr + 8'h01;
          byte_idx  <= 2'h0;
        end
        else
        begin
          // low byte first
          coef_hold[{byte_idx, 3'b000} +: 8] <= bus_s;
          byte_idx <= byte_idx + 2'h1;
        end
      end
      else if (coef_rd)
      begin
        // readback walks bytes in write order
        byte_idx <= byte_idx + 2'h1;
        if (byte_idx == fcrp_pkg::LAST_BYTE)
          coef_ptr <= coef_ptr + 8'h01;
      end
    end
  end

  fcrp_coef_mem u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (coef_ptr[fcrp_pkg::COEF_AW-1:0]),
    .rdata (mem_rdata)
  );

  // read value; coefficient port reads zero outside readback mode
  always_comb
  begin
    reg_view = 8'h00;
    case (sel_s)
      fcrp_pkg::ADDR_FILTER_CFG: reg_view = filter_configuration;
      fcrp_pkg::ADDR_TAP_COUNT:  reg_view = fir_tap_count;
      fcrp_pkg::ADDR_COEF_PORT:
        if (filter_configuration[fcrp_pkg::COEF_RD_BIT] && !ptr_end)
          reg_view = mem_rdata[{byte_idx, 3'b000} +: 8];
      fcrp_pkg::ADDR_IN_FORMAT:  reg_view = input_format;
      fcrp_pkg::ADDR_OUT_TIMING: reg_view = output_timing;
      fcrp_pkg::ADDR_OUT_FORMAT: reg_view = output_format;
      fcrp_pkg::ADDR_SYMMETRY:   reg_view = coefficient_symmetry;
      fcrp_pkg::ADDR_MIX_FORMAT: reg_view = mix_factor_format;
      default:                   reg_view = 8'h00;
    endcase
  end

  // bus driver: latch on read edge, release once strobe rises
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      config_bus_out <= 8'h00;
      config_bus_oe  <= 1'b0;
    end
    else if (rd_fall)
    begin
      config_bus_out <= reg_view;
      config_bus_oe  <= 1'b1;
    end
    else if (read_s)
      config_bus_oe <= 1'b0;
  end

  // decoded fields, registered so every output comes from a flop
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      halfband_stage        <= 3'h0;
      halfband_invalid      <= 1'b0;
      fir_enable            <= 1'b0;
      coef_read_enable      <= 1'b0;
      fir_decimation        <= 4'h8;
      fir_taps              <= 9'h100;
      fir_taps_invalid      <= 1'b0;
      input_word_length     <= 5'h00;
      input_length_invalid  <= 1'b1;
      input_offset_binary   <= 1'b0;
      input_msb_first       <= 1'b0;
      output_bit_clock_div  <= 6'h20;
      output_msb_first      <= 1'b0;
      output_word_length    <= 6'h20;
      output_length_invalid <= 1'b0;
      output_round          <= 1'b0;
      output_offset_binary  <= 1'b0;
      output_gain_double    <= 1'b0;
      coef_symmetry         <= fcrp_pkg::SYM_EVEN;
      symmetry_invalid      <= 1'b0;
      mix_word_length       <= 5'h00;
      mix_length_invalid    <= 1'b1;
      mix_msb_first         <= 1'b0;
      mix_serial_select     <= 1'b0;
    end
    else
    begin
      halfband_stage       <= filter_configuration[fcrp_pkg::HB_LSB +: 3];
      halfband_invalid     <= filter_configuration[fcrp_pkg::HB_LSB +: 3] > fcrp_pkg::HB_MAX;
      fir_enable           <= filter_configuration[fcrp_pkg::FIR_EN_BIT];
      coef_read_enable     <= filter_configuration[fcrp_pkg::COEF_RD_BIT];
      fir_decimation       <= (filter_configuration[fcrp_pkg::DEC_LSB +: 3] == 3'h0) ? 4'h8
                              : {1'b0, filter_configuration[fcrp_pkg::DEC_LSB +: 3]};
      fir_taps             <= (fir_tap_count == 8'h00) ? 9'h100 : {1'b0, fir_tap_count};
      // low counts only matter for symmetric sets
      fir_taps_invalid     <= (fir_tap_count != 8'h00) && (fir_tap_count < fcrp_pkg::TAP_MIN)
                              && (coefficient_symmetry[1:0] != fcrp_pkg::SYM_NONE);
      input_word_length    <= input_format[fcrp_pkg::LEN_LSB +: 5];
      input_length_invalid <= !fcrp_pkg::len_ok(input_format[fcrp_pkg::LEN_LSB +: 5]);
      input_offset_binary  <= input_format[fcrp_pkg::IN_OFFSET_BIT];
      input_msb_first      <= input_format[fcrp_pkg::IN_MSB_BIT];
      output_bit_clock_div <= fcrp_pkg::zero_is_32(output_timing[fcrp_pkg::LEN_LSB +: 5]);
      output_msb_first     <= output_timing[fcrp_pkg::OUT_MSB_BIT];
      output_word_length   <= fcrp_pkg::zero_is_32(output_format[fcrp_pkg::LEN_LSB +: 5]);
      output_length_invalid <= (output_format[fcrp_pkg::LEN_LSB +: 5] != 5'h00)
                               && (output_format[fcrp_pkg::LEN_LSB +: 5] < fcrp_pkg::WORD_MIN);
      output_round         <= output_format[fcrp_pkg::ROUND_BIT];
      output_offset_binary <= output_format[fcrp_pkg::OUT_OFFSET_BIT];
      output_gain_double   <= output_format[fcrp_pkg::GAIN_BIT];
      coef_symmetry        <= coefficient_symmetry[fcrp_pkg::SYM_LSB +: 2];
      symmetry_invalid     <= coefficient_symmetry[fcrp_pkg::SYM_LSB +: 2]
                              > fcrp_pkg::SYM_ODD;
      mix_word_length      <= mix_factor_format[fcrp_pkg::LEN_LSB +: 5];
      mix_length_invalid   <= !fcrp_pkg::len_ok(mix_factor_format[fcrp_pkg::LEN_LSB +: 5]);
      mix_msb_first        <= mix_factor_format[fcrp_pkg::MIX_MSB_BIT];
      mix_serial_select    <= mix_factor_format[fcrp_pkg::MIX_SERIAL_BIT];
    end
  end

  // checks on the design's own behaviour
  property p_store_capture;
    @(posedge mclk) disable iff (!rst_n)
      wr_fall && (sel_s == fcrp_pkg::ADDR_FILTER_CFG) |=> filter_configuration == $past(bus_s);
  endproperty
  a_store_capture: assert property (p_store_capture) else $error("store edge missed register");

  property p_read_hold;
    @(posedge mclk) disable iff (!rst_n)
      rd_fall ##1 !read_s |=> config_bus_oe && $stable(config_bus_out);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data not held");

  property p_read_release;
    @(posedge mclk) disable iff (!rst_n)
      config_bus_oe && read_s |=> !config_bus_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("bus not released");

  property p_decimation_eight;
    @(posedge mclk) disable iff (!rst_n)
      filter_configuration[fcrp_pkg::DEC_LSB +: 3] == 3'h0 |=> fir_decimation == 4'h8;
  endproperty
  a_decimation_eight: assert property (p_decimation_eight) else $error("decimation zero not eight");

  property p_taps_zero;
    @(posedge mclk) disable iff (!rst_n)
      fir_tap_count == 8'h00 |=> fir_taps == 9'h100;
  endproperty
  a_taps_zero: assert property (p_taps_zero) else $error("tap zero not 256");

  property p_coef_no_store;
    @(posedge mclk) disable iff (!rst_n)
      wr_fall && (sel_s == fcrp_pkg::ADDR_COEF_PORT) |=> $stable(fir_tap_count) && $stable(filter_configuration);
  endproperty
  a_coef_no_store: assert property (p_coef_no_store) else $error("coefficient write hit a register");

  property p_commit_fourth;
    @(posedge mclk) disable iff (!rst_n)
      mem_we |-> $past(coef_wr) && ($past(byte_idx) == fcrp_pkg::LAST_BYTE);
  endproperty
  a_commit_fourth: assert property (p_commit_fourth) else $error("commit before fourth byte");

  property p_ptr_reset;
    @(posedge mclk) disable iff (!rst_n)
      (wr_fall || rd_fall) && (sel_s != fcrp_pkg::ADDR_COEF_PORT) |=> coef_ptr == 8'h00 && byte_idx == 2'h0;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not reset");

  property p_unused_zero;
    @(posedge mclk) disable iff (!rst_n)
      rd_fall && (sel_s == fcrp_pkg::ADDR_SYMMETRY) |=> config_bus_out[7:2] == 6'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// self-checking bench for the register port
module tb;
  logic       mclk;      // 100 MHz clock
  logic       rst_n;     // sync reset, active low
  logic       store_n;   // host write strobe
  logic       read_n;    // host read strobe
  logic [2:0] sel;       // host register select
  logic [7:0] drive;     // host bus level
  logic [7:0] bus;       // resolved bus
  logic [7:0] bus_out;   // device bus value
  logic       bus_oe;    // device drives bus
  logic [7:0] cb [10];   // coefficient bytes sent
  logic [7:0] q;         // byte read back
  logic [7:0] d;         // byte written
  logic [2:0] a;         // register chosen
  int         n_errors;  // mismatches
  int         tests_run; // comparisons
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // device wins while enabled; otherwise the host level is on the bus, early in a read included
  assign bus = bus_oe ? bus_out : drive;
  fcrp_host host (.mclk(mclk), .bus(bus), .store_n(store_n), .read_n(read_n), .sel(sel), .drive(drive));
  // decoded outputs are watched through the hierarchy to keep this list short
  fcrp_top dut (.mclk(mclk), .rst_n(rst_n), .store_strobe_n(store_n), .read_strobe_n(read_n),
    .reg_select(sel), .config_bus_in(bus), .config_bus_out(bus_out), .config_bus_oe(bus_oe),
    .halfband_stage(), .halfband_invalid(), .fir_enable(), .coef_read_enable(), .fir_decimation(),
    .fir_taps(), .fir_taps_invalid(), .input_word_length(), .input_length_invalid(),
    .input_offset_binary(), .input_msb_first(), .output_bit_clock_div(), .output_msb_first(),
    .output_word_length(), .output_length_invalid(), .output_round(), .output_offset_binary(),
    .output_gain_double(), .coef_symmetry(), .symmetry_invalid(), .mix_word_length(),
    .mix_length_invalid(), .mix_msb_first(), .mix_serial_select());
  // five-bit count where zero stands for 32
  function automatic logic [5:0] z32(input logic [4:0] v);
    z32 = (v == 5'h00) ? 6'h20 : {1'b0, v};
  endfunction
  // expected decode of one register, packed low-aligned
  function automatic logic [15:0] dec_exp(input logic [2:0] r, input logic [7:0] v);
    logic bad;
    bad = (v[4:0] < 5'h08) || (v[4:0] > 5'h18);
    case (r)
      3'h0: dec_exp = 16'({v[2:0], v[2:0] > 3'h5, v[3], v[4], (v[7:5] == 3'h0) ? 4'h8 : {1'b0, v[7:5]}});
      3'h1: dec_exp = 16'((v == 8'h00) ? 9'h100 : {1'b0, v});
      3'h4: dec_exp = 16'({v[5], z32(v[4:0])});
      3'h5: dec_exp = 16'({v[7:5], (v[4:0] != 5'h00) && (v[4:0] < 5'h08), z32(v[4:0])});
      3'h6: dec_exp = 16'({v[1:0] == 2'h3, v[1:0]});
      default: dec_exp = 16'({v[6:5], bad, v[4:0]});
    endcase
  endfunction
  // same packing taken from the device outputs
  function automatic logic [15:0] dec_got(input logic [2:0] r);
    case (r)
      3'h0: dec_got = 16'({dut.halfband_stage, dut.halfband_invalid, dut.fir_enable, dut.coef_read_enable,
                          dut.fir_decimation});
      3'h1: dec_got = 16'(dut.fir_taps);
      3'h3: dec_got = 16'({dut.input_msb_first, dut.input_offset_binary, dut.input_length_invalid,
                          dut.input_word_length});
      3'h4: dec_got = 16'({dut.output_msb_first, dut.output_bit_clock_div});
      3'h5: dec_got = 16'({dut.output_gain_double, dut.output_offset_binary, dut.output_round,
                          dut.output_length_invalid, dut.output_word_length});
      3'h6: dec_got = 16'({dut.symmetry_invalid, dut.coef_symmetry});
      default: dec_got = 16'({dut.mix_serial_select, dut.mix_msb_first, dut.mix_length_invalid,
                             dut.mix_word_length});
    endcase
  endfunction
  // bits that read back; unused ones stay zero
  function automatic logic [7:0] mask(input logic [2:0] r);
    case (r)
      3'h3: mask = fcrp_pkg::MASK_IN_FORMAT;
      3'h4: mask = fcrp_pkg::MASK_OUT_TIMING;
      3'h6: mask = fcrp_pkg::MASK_SYMMETRY;
      3'h7: mask = fcrp_pkg::MASK_MIX_FORMAT;
      default: mask = fcrp_pkg::MASK_FULL;
    endcase
  endfunction
  task automatic chk_dec(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_dec({8'h00, got}, {8'h00, exp});
  endtask
  // read, then confirm the bus is let go once the strobe is back high
  task automatic rd(input logic [2:0] r, output logic [7:0] v);
    host.rd(r, v);
    chk_byte({7'h00, bus_oe}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if ((n_errors == 0) && (tests_run > 0))
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #200000;
    n_errors++;
    print_verdict();
  end
  // main sequence: zero and all-ones corners first, then random traffic
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    void'($urandom(32'h0b88));
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 48; i++)
    begin
      a = (i < 16) ? 3'(i % 8) : 3'($urandom_range(7));
      d = (i < 8) ? 8'h00 : ((i < 16) ? 8'hff : 8'($urandom));
      if (a == fcrp_pkg::ADDR_COEF_PORT)
        a = fcrp_pkg::ADDR_FILTER_CFG;
      if (a == fcrp_pkg::ADDR_SYMMETRY)
        d[7:2] = 6'h00;
      host.wr(a, d);
      chk_dec(dec_got(a), dec_exp(a, d));
      rd(a, q);
      chk_byte(q, d & mask(a));
    end
    // low tap count is flagged on an even-symmetric set
    host.wr(fcrp_pkg::ADDR_SYMMETRY, 8'h00);
    host.wr(fcrp_pkg::ADDR_TAP_COUNT, 8'h02);
    chk_byte({7'h00, dut.fir_taps_invalid}, 8'h01);
    // random traffic may leave readback on over storage never written
    host.wr(fcrp_pkg::ADDR_FILTER_CFG, 8'h08); // readback off before loading
    rd(fcrp_pkg::ADDR_COEF_PORT, q);
    chk_byte(q, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      cb[i] = 8'($urandom);
      host.wr(fcrp_pkg::ADDR_COEF_PORT, cb[i]);
    end
    host.wr(fcrp_pkg::ADDR_SYMMETRY, 8'h01); // drops the partial third word
    host.wr(fcrp_pkg::ADDR_TAP_COUNT, 8'h04); // two words loaded, doubled
    for (int j = 0; j < 2; j++)
    begin
      host.wr(fcrp_pkg::ADDR_FILTER_CFG, 8'h18); // pointer back to word 0
      for (int i = 0; i < 8; i++)
      begin
        rd(fcrp_pkg::ADDR_COEF_PORT, q);
        chk_byte(q, cb[i]);
      end
      for (int i = 0; i < 4; i++)
        host.wr(fcrp_pkg::ADDR_COEF_PORT, ~cb[i]); // must be ignored while readback is on
    end
    print_verdict();
  end
endmodule
